// ===== include/sco_pkg.sv
// shared constants and decode helpers for the system reset status and options bank
package sco_pkg;

    // ==================================================
    // bus widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // ==================================================
    // register addresses
    localparam logic [15:0] ADDR_RESET_STATUS = 16'h1800;
    localparam logic [15:0] ADDR_DEBUG_FORCE = 16'h1801;
    localparam logic [15:0] ADDR_SYS_OPTIONS = 16'h1802;
    localparam logic [15:0] ADDR_PART_HIGH = 16'h1806;
    localparam logic [15:0] ADDR_PART_LOW = 16'h1807;

    // ==================================================
    // memory map gaps and register area
    localparam logic [15:0] RAM_GAP_LO = 16'h0880;
    localparam logic [15:0] RAM_GAP_HI = 16'h17FF;
    localparam logic [15:0] FLASH_GAP_LO = 16'h182C;
    localparam logic [15:0] FLASH_GAP_HI = 16'hBFFF;
    localparam logic [15:0] REG_AREA_LO = 16'h1800;
    localparam logic [15:0] REG_AREA_HI = 16'h182B;

    // ==================================================
    // reset cause flag positions
    localparam int FLAG_POWER_ON = 7;
    localparam int FLAG_PIN = 6;
    localparam int FLAG_WDOG = 5;
    localparam int FLAG_BAD_OPCODE = 4;
    localparam int FLAG_BAD_ADDR = 3;
    localparam int FLAG_CLKGEN = 2;
    localparam int FLAG_LOW_VOLT = 1;

    // ==================================================
    // option fields and reset values
    localparam int OPT_WDOG_EN = 7;
    localparam int OPT_WDOG_LONG = 6;
    localparam int OPT_HALT_EN = 5;
    localparam int OPT_DBG_PIN = 1;
    localparam logic [7:0] OPT_RESET = 8'hC2;
    localparam logic [7:0] OPT_MASK = 8'hE2;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam int FORCE_BIT = 0;

    // ==================================================
    // timing
    localparam logic [3:0] RST_HOLD_CYCLES = 4'h4;
    localparam int WDOG_W = 19;
    localparam int WDOG_SHORT_EXP = 13;
    localparam int WDOG_LONG_EXP = 18;

    // ==================================================
    // decode helpers
    function automatic logic is_bad_addr(input logic [15:0] a);
        return ((a >= RAM_GAP_LO) && (a <= RAM_GAP_HI)) ||
               ((a >= FLASH_GAP_LO) && (a <= FLASH_GAP_HI));
    endfunction

    function automatic logic is_reg_area(input logic [15:0] a);
        return (a >= REG_AREA_LO) && (a <= REG_AREA_HI);
    endfunction

endpackage

// ===== src/sco_addr_chk.sv
// registered illegal address detector
`timescale 1ns/1ps
module sco_addr_chk (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // bus access
    input wire logic [sco_pkg::ADDR_W-1:0] addr_in,
    input wire logic access_in,
    // result
    output logic bad_out
);
    import sco_pkg::*;

    typedef struct packed {
        logic bad;
    } sco_chk_t;

    sco_chk_t q;
    sco_chk_t n;

    always_comb begin
        n = q;
        // register windows never count as illegal, only the gaps
        n.bad = access_in && is_bad_addr(addr_in);
        if (!resetn_in) begin
            n.bad = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        q <= n;
    end

    assign bad_out = q.bad;
endmodule

// ===== src/sco_reset_gen.sv
// internal reset sequencer that holds the system reset and remembers its cause
`timescale 1ns/1ps
module sco_reset_gen (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // requests
    input wire logic force_in,
    input wire logic [7:0] req_in,
    // reset out
    output logic hold_out,
    output logic [7:0] cause_out
);
    import sco_pkg::*;

    typedef enum logic [1:0] {
        RG_IDLE = 2'b01,
        RG_HOLD = 2'b10
    } sco_rg_state_t;

    typedef struct packed {
        sco_rg_state_t st;
        logic [3:0] cnt;
        logic [7:0] cause;
    } sco_rg_t;

    sco_rg_t q;
    sco_rg_t n;

    always_comb begin
        n = q;
        case (q.st)
            RG_IDLE: begin
                if (force_in || (|req_in)) begin
                    n.st = RG_HOLD;
                    n.cnt = RST_HOLD_CYCLES - 4'h1;
                    // a debug forced reset reports no cause at all
                    n.cause = force_in ? FLAGS_RESET : req_in;
                end
            end
            RG_HOLD: begin
                if (q.cnt == 4'h0) begin
                    n.st = RG_IDLE;
                end else begin
                    n.cnt = q.cnt - 4'h1;
                end
            end
            default: begin
                n.st = RG_IDLE;
            end
        endcase
        if (!resetn_in) begin
            n.st = RG_IDLE;
            n.cnt = 4'h0;
            n.cause = FLAGS_RESET;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        q <= n;
    end

    assign hold_out = (q.st == RG_HOLD);
    assign cause_out = q.cause;
endmodule

// ===== src/sco_sys_cfg.sv
// system reset status, debug force reset, write-once options and part number bank
`timescale 1ns/1ps
module sco_sys_cfg #(
    parameter logic [11:0] PART_ID = 12'h5A3, // arbitrary value
    parameter int unsigned WDOG_SHORT_CYCLES = 1 << sco_pkg::WDOG_SHORT_EXP,
    parameter int unsigned WDOG_LONG_CYCLES = 1 << sco_pkg::WDOG_LONG_EXP
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // internal bus
    input wire logic [sco_pkg::ADDR_W-1:0] bus_addr_in,
    input wire logic bus_rd_in,
    input wire logic bus_wr_in,
    input wire logic bus_debug_in,
    input wire logic [sco_pkg::DATA_W-1:0] bus_wdata_in,
    output logic [sco_pkg::DATA_W-1:0] bus_rdata_out,
    // external reset causes
    input wire logic power_on_in,
    input wire logic pin_reset_in,
    // internal reset sources, halt request and wake
    input wire logic wdog_timeout_in,
    input wire logic illegal_opcode_in,
    input wire logic clock_generator_fault_in,
    input wire logic halt_exec_in,
    input wire logic wake_in,
    // low voltage detector
    input wire logic low_voltage_trip_in,
    input wire logic low_voltage_enable_in,
    input wire logic low_voltage_reset_enable_in,
    input wire logic low_voltage_stop_enable_in,
    output logic low_voltage_active_out,
    // watchdog control
    output logic watchdog_enable_out,
    output logic [sco_pkg::WDOG_W-1:0] watchdog_limit_out,
    output logic watchdog_restart_out,
    // halt mode
    output logic halt_mode_out,
    // debug pin mux
    input wire logic general_output_data_in,
    output logic debug_pin_enable_out,
    output logic general_output_pin_out,
    output logic general_output_oe_out,
    // system reset
    output logic sys_reset_out
);
    import sco_pkg::*;

    // ==================================================
    // state
    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] opt;
        logic locked;
        logic in_halt;
        logic [7:0] rdata;
        logic wdog_restart;
        logic force_req;
    } sco_state_t;

    sco_state_t q;
    sco_state_t n;

    logic gen_hold;
    logic [7:0] gen_cause;
    logic bad_addr;
    logic in_reset;
    logic lowv_req;
    logic [7:0] req_vec;
    logic [7:0] cause_now;
    logic opt_wr_ok;

    // ==================================================
    // read decode
    function automatic logic [7:0] read_mux(input logic [15:0] a, input logic [7:0] flags,
                                            input logic [7:0] opt);
        if (a == ADDR_RESET_STATUS) begin
            return flags;
        end else if (a == ADDR_DEBUG_FORCE) begin
            return 8'h00;
        end else if (a == ADDR_SYS_OPTIONS) begin
            return opt & OPT_MASK;
        end else if (a == ADDR_PART_HIGH) begin
            return {4'h0, PART_ID[11:8]};
        end else if (a == ADDR_PART_LOW) begin
            return PART_ID[7:0];
        end else begin
            return 8'h00;
        end
    endfunction

    // ==================================================
    // reset sources
    assign in_reset = !resetn_in || gen_hold;
    // detector stays dead in halt unless told to keep running
    assign low_voltage_active_out = low_voltage_enable_in &&
                                    (!q.in_halt || low_voltage_stop_enable_in);
    assign lowv_req = low_voltage_active_out && low_voltage_reset_enable_in &&
                      low_voltage_trip_in;

    always_comb begin
        req_vec = 8'h00;
        if (!in_reset) begin
            req_vec[FLAG_WDOG] = wdog_timeout_in && q.opt[OPT_WDOG_EN];
            req_vec[FLAG_BAD_OPCODE] = illegal_opcode_in ||
                                       (halt_exec_in && !q.opt[OPT_HALT_EN]);
            req_vec[FLAG_BAD_ADDR] = bad_addr;
            req_vec[FLAG_CLKGEN] = clock_generator_fault_in;
            req_vec[FLAG_LOW_VOLT] = lowv_req;
        end
    end

    sco_addr_chk u_addr_chk (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .addr_in(bus_addr_in),
        .access_in((bus_rd_in || bus_wr_in) && !in_reset),
        .bad_out(bad_addr)
    );

    sco_reset_gen u_reset_gen (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .force_in(q.force_req),
        .req_in(req_vec),
        .hold_out(gen_hold),
        .cause_out(gen_cause)
    );

    // ==================================================
    // next state
    always_comb begin
        n = q;
        n.wdog_restart = 1'b0;
        n.force_req = 1'b0;
        cause_now = gen_hold ? gen_cause : FLAGS_RESET;
        if (!resetn_in) begin
            cause_now = FLAGS_RESET;
            cause_now[FLAG_POWER_ON] = power_on_in;
            cause_now[FLAG_PIN] = pin_reset_in && !power_on_in;
            cause_now[FLAG_LOW_VOLT] = power_on_in;
        end
        if (in_reset) begin
            n.flags = cause_now;
            // a pure low voltage reset leaves the power-on flag as it was
            if (cause_now[FLAG_LOW_VOLT] && !cause_now[FLAG_POWER_ON]) begin
                n.flags[FLAG_POWER_ON] = q.flags[FLAG_POWER_ON];
            end
            n.opt = OPT_RESET;
            n.locked = 1'b0;
            n.in_halt = 1'b0;
            n.rdata = 8'h00;
        end else begin
            if (bus_wr_in) begin
                if (bus_addr_in == ADDR_RESET_STATUS) begin
                    n.wdog_restart = 1'b1;
                end else if (bus_addr_in == ADDR_DEBUG_FORCE) begin
                    n.force_req = bus_debug_in && bus_wdata_in[FORCE_BIT];
                end else if (bus_addr_in == ADDR_SYS_OPTIONS) begin
                    if (!q.locked) begin
                        n.opt = bus_wdata_in & OPT_MASK;
                        n.locked = 1'b1;
                    end
                end
            end
            if (bus_rd_in) begin
                n.rdata = read_mux(bus_addr_in, q.flags, q.opt);
            end
            if (halt_exec_in && q.opt[OPT_HALT_EN]) begin
                n.in_halt = 1'b1;
            end else if (wake_in) begin
                n.in_halt = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        q <= n;
    end

    // ==================================================
    // outputs
    assign bus_rdata_out = q.rdata;
    assign sys_reset_out = gen_hold;
    assign watchdog_restart_out = q.wdog_restart;
    assign watchdog_enable_out = q.opt[OPT_WDOG_EN];
    // limit decoded from the stored option so it never glitches on bus traffic
    assign watchdog_limit_out = q.opt[OPT_WDOG_LONG] ? WDOG_W'(WDOG_LONG_CYCLES) :
                                WDOG_W'(WDOG_SHORT_CYCLES);
    assign halt_mode_out = q.in_halt;
    assign debug_pin_enable_out = q.opt[OPT_DBG_PIN];
    assign general_output_pin_out = general_output_data_in;
    assign general_output_oe_out = !q.opt[OPT_DBG_PIN];

    // ==================================================
    // checks
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);

    sequence s_debug_force;
        !in_reset && bus_wr_in && bus_debug_in && (bus_addr_in == ADDR_DEBUG_FORCE) &&
        bus_wdata_in[FORCE_BIT];
    endsequence

    sequence s_reset_released_clean;
        !sys_reset_out && (q.flags == FLAGS_RESET);
    endsequence

    a_force_resets:
    assert property (s_debug_force |-> ##2 sys_reset_out [*4])
        else $error("debug force write did not hold reset");

    a_force_clears_flags:
    assert property (s_debug_force |-> ##2 sys_reset_out ##[1:8] s_reset_released_clean)
        else $error("flags not clear after debug forced reset");

    a_user_force_ignored:
    assert property (!in_reset && bus_wr_in && !bus_debug_in &&
                     (bus_addr_in == ADDR_DEBUG_FORCE) |=> !q.force_req)
        else $error("user write to force register took effect");

    a_force_reads_zero:
    assert property (!in_reset && bus_rd_in && (bus_addr_in == ADDR_DEBUG_FORCE)
                     |=> bus_rdata_out == 8'h00)
        else $error("force register read not zero");

    a_bad_addr_reset:
    assert property (!in_reset && (bus_rd_in || bus_wr_in) && is_bad_addr(bus_addr_in)
                     |-> ##2 sys_reset_out ##4 (q.flags[FLAG_BAD_ADDR] || !resetn_in))
        else $error("gap access did not cause bad address reset");

    a_reg_area_legal:
    assert property (is_reg_area(bus_addr_in) && (bus_rd_in || bus_wr_in) |=> !bad_addr)
        else $error("register area access flagged illegal");

    a_opt_reads:
    assert property (!in_reset && bus_rd_in && (bus_addr_in == ADDR_SYS_OPTIONS)
                     |=> (bus_rdata_out[3:2] == 2'b00) &&
                         (bus_rdata_out == (q.opt & OPT_MASK)))
        else $error("options read wrong");

    a_opt_first_write:
    assert property (!in_reset && !q.locked && bus_wr_in &&
                     (bus_addr_in == ADDR_SYS_OPTIONS)
                     |=> q.locked && (q.opt == ($past(bus_wdata_in) & OPT_MASK)))
        else $error("first options write not taken");

    a_opt_later_write:
    assert property (!in_reset && q.locked && bus_wr_in && (bus_addr_in == ADDR_SYS_OPTIONS)
                     |=> $stable(q.opt))
        else $error("locked options changed");

    a_opt_defaults:
    assert property ($fell(gen_hold) |-> (q.opt == OPT_RESET) && !q.locked &&
                     debug_pin_enable_out && watchdog_enable_out)
        else $error("options not at defaults after reset");

    a_halt_disabled:
    assert property (!in_reset && halt_exec_in && !q.opt[OPT_HALT_EN]
                     |=> sys_reset_out && !halt_mode_out)
        else $error("halt while disabled did not reset");

    a_lowv_in_halt:
    assert property (q.in_halt && !low_voltage_stop_enable_in |-> !low_voltage_active_out)
        else $error("low voltage detector active in halt");

    a_status_write:
    assert property (!in_reset && bus_wr_in && (bus_addr_in == ADDR_RESET_STATUS)
                     |=> watchdog_restart_out && $stable(q.flags))
        else $error("status write did not restart watchdog or changed flags");

    a_part_high:
    assert property (!in_reset && bus_rd_in && (bus_addr_in == ADDR_PART_HIGH)
                     |=> bus_rdata_out == {4'h0, PART_ID[11:8]})
        else $error("part number high read wrong");

    a_reset_cause_latch:
    assert property ($rose(resetn_in) |-> (q.flags[FLAG_POWER_ON] == $past(power_on_in)) &&
                     (q.flags[FLAG_LOW_VOLT] == $past(power_on_in)) &&
                     (q.flags[FLAG_PIN] == ($past(pin_reset_in) && !$past(power_on_in))))
        else $error("reset cause flags do not match the external sources");

    a_status_read:
    assert property (!in_reset && bus_rd_in && (bus_addr_in == ADDR_RESET_STATUS)
                     |=> bus_rdata_out == $past(q.flags))
        else $error("status read does not return the flags");

    a_flags_only_reset:
    assert property ($changed(q.flags) |-> $past(in_reset))
        else $error("flags changed outside a reset");

    a_wdog_cause:
    assert property (!in_reset && !q.force_req && wdog_timeout_in && q.opt[OPT_WDOG_EN]
                     |=> sys_reset_out ##4 q.flags[FLAG_WDOG])
        else $error("enabled watchdog timeout did not reset with its flag");

    a_clkgen_cause:
    assert property (!in_reset && !q.force_req && clock_generator_fault_in
                     |=> sys_reset_out ##4 q.flags[FLAG_CLKGEN])
        else $error("clock generator request did not reset with its flag");

    a_lowv_cause:
    assert property (!in_reset && !q.force_req && lowv_req
                     |=> sys_reset_out ##4 q.flags[FLAG_LOW_VOLT])
        else $error("low voltage trip did not reset with its flag");

    a_lowv_stop_kept:
    assert property (q.in_halt && low_voltage_stop_enable_in && low_voltage_enable_in
                     |-> low_voltage_active_out)
        else $error("low voltage detector off in halt although kept");

    a_halt_enter:
    assert property (!in_reset && halt_exec_in && q.opt[OPT_HALT_EN] |=> halt_mode_out)
        else $error("enabled halt not entered");

    a_part_low:
    assert property (!in_reset && bus_rd_in && (bus_addr_in == ADDR_PART_LOW)
                     |=> bus_rdata_out == PART_ID[7:0])
        else $error("part number low read wrong");

    // only a reset or the first options write may move the limit
    assign opt_wr_ok = !in_reset && bus_wr_in && !q.locked &&
                       (bus_addr_in == ADDR_SYS_OPTIONS);

    a_limit_source:
    assert property ($changed(watchdog_limit_out) |-> $past(in_reset) || $past(opt_wr_ok))
        else $error("watchdog limit changed without reset or first options write");

    a_wdog_limit:
    assert property (watchdog_limit_out == (q.opt[OPT_WDOG_LONG] ?
                     WDOG_W'(WDOG_LONG_CYCLES) : WDOG_W'(WDOG_SHORT_CYCLES)))
        else $error("watchdog limit does not follow select");
endmodule

// ===== verif/sco_host_model.sv
// bus master model of the processor core and the debug host
`timescale 1ns/1ps
module sco_host_model (
    // clock
    input wire logic clk_sys_in,
    // bus out
    output logic [15:0] bus_addr_out,
    output logic bus_rd_out,
    output logic bus_wr_out,
    output logic bus_debug_out,
    output logic [7:0] bus_wdata_out,
    // bus in
    input wire logic [7:0] bus_rdata_in
);
    initial begin
        bus_addr_out = 16'h0000;
        bus_rd_out = 1'b0;
        bus_wr_out = 1'b0;
        bus_debug_out = 1'b0;
        bus_wdata_out = 8'h00;
    end

    // ==================================================
    // one access, request held up to its sampling edge
    // released address and data lines show the inverse so stale values never match
    task automatic xfer(input logic wr, input logic dbg, input logic [15:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_sys_in);
        #1;
        bus_addr_out = a;
        bus_wdata_out = d;
        bus_rd_out = !wr;
        bus_wr_out = wr;
        bus_debug_out = dbg;
        @(posedge clk_sys_in);
        #1;
        q = bus_rdata_in;
        bus_rd_out = 1'b0;
        bus_wr_out = 1'b0;
        bus_debug_out = 1'b0;
        bus_addr_out = ~a;
        bus_wdata_out = ~d;
    endtask
endmodule

// ===== verif/system_reset_status_and_options_tb_top.sv
// self-checking bench for the reset status and options bank
`timescale 1ns/1ps
module system_reset_status_and_options_tb_top;
    import sco_pkg::*;
    localparam logic [11:0] PID = 12'h3C7; // arbitrary value
    logic clk_sys_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [15:0] ba;
    logic brd, bwr, bdbg;
    logic [7:0] bwd, rdat;
    logic por = 1'b1, wdt = 1'b0, ilop = 1'b0, cgf = 1'b0, halt = 1'b0;
    logic wake = 1'b0, lvt = 1'b0, lvse = 1'b0, pin = 1'b0, lvre = 1'b1, gout = 1'b1;
    logic lva, wde, wrst, hmode, dpe, gop, goe, srst;
    logic [18:0] wlim;
    int bad_count = 0;
    int n_compared = 0;
    logic [15:0] bad_a [0:3] = '{16'h0880, 16'h17FF, 16'h182C, 16'hBFFF};
    logic [7:0] exp_f [0:8] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h20, 8'h04, 8'h02, 8'h10,
                                8'h10};

    always #5 clk_sys_in = ~clk_sys_in;

    sco_host_model host (.clk_sys_in(clk_sys_in), .bus_addr_out(ba), .bus_rd_out(brd),
        .bus_wr_out(bwr), .bus_debug_out(bdbg), .bus_wdata_out(bwd), .bus_rdata_in(rdat));

    sco_sys_cfg #(.PART_ID(PID), .WDOG_SHORT_CYCLES(8), .WDOG_LONG_CYCLES(16)) uut (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .bus_addr_in(ba),
        .bus_rd_in(brd), .bus_wr_in(bwr), .bus_debug_in(bdbg), .bus_wdata_in(bwd),
        .bus_rdata_out(rdat), .power_on_in(por), .pin_reset_in(pin),
        .wdog_timeout_in(wdt), .illegal_opcode_in(ilop), .clock_generator_fault_in(cgf),
        .halt_exec_in(halt), .wake_in(wake), .low_voltage_trip_in(lvt),
        .low_voltage_enable_in(1'b1), .low_voltage_reset_enable_in(lvre),
        .low_voltage_stop_enable_in(lvse), .low_voltage_active_out(lva),
        .watchdog_enable_out(wde), .watchdog_limit_out(wlim),
        .watchdog_restart_out(wrst), .halt_mode_out(hmode),
        .general_output_data_in(gout), .debug_pin_enable_out(dpe),
        .general_output_pin_out(gop), .general_output_oe_out(goe),
        .sys_reset_out(srst));

    // ==================================================
    // compare and verdict
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task test_done;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==================================================
    // access and event helpers
    task rd(input logic [15:0] a, output logic [7:0] q);
        host.xfer(1'b0, 1'b0, a, 8'h00, q);
    endtask

    task wr(input logic [15:0] a, input logic [7:0] d, input logic dbg);
        logic [7:0] q;
        host.xfer(1'b1, dbg, a, d, q);
    endtask

    task pulse(input int k);
        @(posedge clk_sys_in);
        #1;
        case (k)
            0: wdt = 1'b1;
            1: cgf = 1'b1;
            2: lvt = 1'b1;
            3: halt = 1'b1;
            4: ilop = 1'b1;
            default: wake = 1'b1;
        endcase
        @(posedge clk_sys_in);
        #1;
        wdt = 1'b0;
        cgf = 1'b0;
        lvt = 1'b0;
        halt = 1'b0;
        ilop = 1'b0;
        wake = 1'b0;
    endtask

    // bounded wait, then counts the cycles the reset stands
    task wait_rst(output int hi);
        int n;
        n = 0;
        hi = 0;
        while (srst !== 1'b1 && n < 12) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        while (srst === 1'b1 && hi < 12) begin
            @(posedge clk_sys_in);
            #1;
            hi++;
        end
    endtask

    task no_rst;
        int n;
        n = 0;
        repeat (8) begin
            @(posedge clk_sys_in);
            #1;
            if (srst !== 1'b0) n++;
        end
        check(n, 0);
    endtask

    // ==================================================
    // tests
    initial begin
        logic [7:0] q;
        int h;
        repeat (12) @(posedge clk_sys_in);
        #1;
        resetn_in = 1'b1;
        por = 1'b0;
        rd(ADDR_RESET_STATUS, q);
        check(q, 8'h82);
        rd(ADDR_SYS_OPTIONS, q);
        check(q, OPT_RESET);
        check({wde, dpe, goe}, 3'b110);
        check(wlim, 19'd16);
        rd(ADDR_PART_HIGH, q);
        check(q, {4'h0, PID[11:8]});
        rd(ADDR_PART_LOW, q);
        check(q, PID[7:0]);
        wr(ADDR_DEBUG_FORCE, 8'h01, 1'b0);
        no_rst();
        rd(ADDR_DEBUG_FORCE, q);
        check(q, 8'h00);
        rd(16'h1803, q);
        check(q, 8'h00);
        rd(REG_AREA_HI, q);
        no_rst();
        wr(ADDR_RESET_STATUS, 8'hFF, 1'b0);
        check(wrst, 1'b1);
        @(posedge clk_sys_in);
        #1;
        check(wrst, 1'b0);
        rd(ADDR_RESET_STATUS, q);
        check(q, 8'h82);
        // init software writes options once; the second write must bounce
        wr(ADDR_SYS_OPTIONS, 8'h2C, 1'b0);
        rd(ADDR_SYS_OPTIONS, q);
        check(q, 8'h20);
        wr(ADDR_SYS_OPTIONS, 8'hC2, 1'b0);
        rd(ADDR_SYS_OPTIONS, q);
        check(q, 8'h20);
        check({wde, dpe, goe, gop}, 4'b0011);
        check(wlim, 19'd8);
        gout = 1'b0;
        #1;
        check(gop, 1'b0);
        pulse(0);
        no_rst();
        check(lva, 1'b1);
        pulse(3);
        check({hmode, lva}, 2'b10);
        lvse = 1'b1;
        #1;
        check(lva, 1'b1);
        @(posedge clk_sys_in);
        #1;
        lvse = 1'b0;
        pulse(5);
        check(hmode, 1'b0);
        // trip with the reset enable off must not reset
        lvre = 1'b0;
        pulse(2);
        no_rst();
        lvre = 1'b1;
        wr(ADDR_DEBUG_FORCE, 8'h01, 1'b1);
        wait_rst(h);
        check(h, RST_HOLD_CYCLES);
        rd(ADDR_RESET_STATUS, q);
        check(q, 8'h00);
        rd(ADDR_SYS_OPTIONS, q);
        check(q, OPT_RESET);
        // gap edges, then each internal source; defaults return each time
        for (int i = 0; i < 9; i++) begin
            if (i < 4) rd(bad_a[i], q);
            else pulse(i - 4);
            wait_rst(h);
            check(h, RST_HOLD_CYCLES);
            rd(ADDR_RESET_STATUS, q);
            check(q, exp_f[i]);
        end
        // mid-run pin reset, then power-on; each must unlock the options again
        for (int j = 0; j < 2; j++) begin
            wr(ADDR_SYS_OPTIONS, 8'h00, 1'b0);
            @(posedge clk_sys_in);
            #1;
            resetn_in = 1'b0;
            pin = 1'b1;
            por = (j == 1);
            repeat (2) @(posedge clk_sys_in);
            #1;
            resetn_in = 1'b1;
            pin = 1'b0;
            por = 1'b0;
            rd(ADDR_RESET_STATUS, q);
            check(q, j ? 8'h82 : 8'h40);
            rd(ADDR_SYS_OPTIONS, q);
            check(q, OPT_RESET);
        end
        // low voltage reset after power-on keeps the power-on flag
        pulse(2);
        wait_rst(h);
        check(h, RST_HOLD_CYCLES);
        rd(ADDR_RESET_STATUS, q);
        check(q, 8'h82);
        test_done;
    end

    // the run needs a few microseconds; this limit only catches a hang
    initial begin
        #50us;
        bad_count++;
        test_done;
    end
endmodule
